// file: hdl/rtcbk_top.sv
// Purpose: real-time counter, alarm, periodic tick, calibration out, backup store
// Assumes: source clocks arrive as one-cycle enable pulses on clk_i
// Notes: srst_i is the system reset; it never touches the backup store
//
// Summary of operation
// R01 - Forty-two 16-bit backup registers hold 84 bytes of data.
// R02 - Backup contents survive system reset, power reset and standby wake-up.
// R03 - Counters run continuously and raise an alarm and a periodic interrupt.
// R04 - Counter clock selects crystal tick, low-speed RC tick or high-speed tick divided by 128.
// R05 - A 512 Hz calibration output can be driven from the crystal clock.
// R06 - A programmable 32-bit counter raises an alarm on reaching the compare value.
// R07 - A 20-bit prescaler defaults to a one-second tick from a 32.768 kHz source.
// R08 - Prescaler divides by reload plus one, reload 32767 at reset, tick bumps counter and flag.
`default_nettype none
module rtcbk_top #(
    parameter int PRE_W = rtcbk_pkg::PRE_WIDTH,
    parameter int CNT_W = rtcbk_pkg::CNT_WIDTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // source ticks
    input wire logic lse_tick_i,
    input wire logic lsi_tick_i,
    input wire logic hse_tick_i,
    // control
    input wire rtcbk_pkg::rtcbk_src_t src_sel_i,
    input wire logic cal_en_i,
    input wire logic pre_load_i,
    input wire logic [PRE_W-1:0] pre_reload_i,
    input wire logic cnt_load_i,
    input wire logic [CNT_W-1:0] cnt_value_i,
    input wire logic alarm_load_i,
    input wire logic [CNT_W-1:0] alarm_value_i,
    input wire logic sec_clr_i,
    input wire logic alarm_clr_i,
    // backup store
    input wire logic bkp_wr_i,
    input wire logic [rtcbk_pkg::BKP_AW-1:0] bkp_addr_i,
    input wire logic [rtcbk_pkg::BKP_WIDTH-1:0] bkp_wdata_i,
    output logic [rtcbk_pkg::BKP_WIDTH-1:0] bkp_rdata_o,
    // status
    output logic [CNT_W-1:0] count_o,
    output logic sec_flag_o,
    output logic alarm_flag_o,
    output logic sec_irq_o,
    output logic alarm_irq_o,
    output logic cal_out_o
);
    logic [PRE_W-1:0] reload_ff, nxt_reload;
    logic [PRE_W-1:0] pre_ff, nxt_pre;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] alarm_ff, nxt_alarm;
    logic [rtcbk_pkg::HSE_DIV_W-1:0] hdiv_ff;
    logic [rtcbk_pkg::CAL_DIV_W-1:0] cdiv_ff;
    logic hse_div_ff, sec_ff, alm_ff, sirq_ff, airq_ff, cal_ff;

    // high-speed tick divided by 128 [R04]
    wire hdiv_wrap = (hdiv_ff == rtcbk_pkg::HSE_DIV_W'(rtcbk_pkg::HSE_DIV - 1));
    wire src_tick = (src_sel_i == rtcbk_pkg::RTCBK_SRC_LSE) ? lse_tick_i :
                    (src_sel_i == rtcbk_pkg::RTCBK_SRC_LSI) ? lsi_tick_i :
                    (src_sel_i == rtcbk_pkg::RTCBK_SRC_HSE) ? hse_div_ff : 1'b0; // [R04]

    // prescaler divides by reload plus one [R07] [R08]
    wire pre_zero = (pre_ff == '0);
    wire tick = src_tick && pre_zero;
    assign nxt_reload = pre_load_i ? pre_reload_i : reload_ff;
    assign nxt_pre = pre_load_i ? pre_reload_i :
                     !src_tick ? pre_ff :
                     pre_zero ? reload_ff : pre_ff - 1'b1; // [R08]
    // load wins over a same-cycle tick so software sees its own value [R06]
    assign nxt_cnt = cnt_load_i ? cnt_value_i : tick ? cnt_ff + 1'b1 : cnt_ff; // [R03] [R08]
    assign nxt_alarm = alarm_load_i ? alarm_value_i : alarm_ff;
    wire alarm_hit = tick && (cnt_ff + 1'b1 == alarm_ff) && !cnt_load_i; // [R06]
    // set beats clear on the same edge
    wire nxt_sec = tick || (sec_ff && !sec_clr_i); // [R08]
    wire nxt_alm = alarm_hit || (alm_ff && !alarm_clr_i); // [R06]

    // 512 Hz from 32.768 kHz: toggle every 32 crystal ticks, period 64 [R05]
    wire cdiv_half = (cdiv_ff[rtcbk_pkg::CAL_DIV_W-2:0] == '1);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reload_ff <= rtcbk_pkg::PRE_RELOAD_RST[PRE_W-1:0];
            pre_ff <= rtcbk_pkg::PRE_RELOAD_RST[PRE_W-1:0];
            cnt_ff <= rtcbk_pkg::CNT_RST[CNT_W-1:0];
            alarm_ff <= rtcbk_pkg::ALARM_RST[CNT_W-1:0];
            hdiv_ff <= '0;
            hse_div_ff <= 1'b0;
            cdiv_ff <= '0;
            cal_ff <= 1'b0;
            sec_ff <= 1'b0;
            alm_ff <= 1'b0;
            sirq_ff <= 1'b0;
            airq_ff <= 1'b0;
        end else begin
            reload_ff <= nxt_reload;
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            alarm_ff <= nxt_alarm;
            if (hse_tick_i) begin
                hdiv_ff <= hdiv_wrap ? '0 : hdiv_ff + 1'b1;
            end
            hse_div_ff <= hse_tick_i && hdiv_wrap; // [R04]
            if (lse_tick_i) begin
                cdiv_ff <= cdiv_ff + 1'b1;
            end
            cal_ff <= cal_en_i && (cal_ff ^ (lse_tick_i && cdiv_half)); // [R05]
            sec_ff <= nxt_sec;
            alm_ff <= nxt_alm;
            sirq_ff <= tick; // [R03]
            airq_ff <= alarm_hit; // [R03]
        end
    end

    // outputs straight from flip-flops
    assign count_o = cnt_ff;
    assign sec_flag_o = sec_ff;
    assign alarm_flag_o = alm_ff;
    assign sec_irq_o = sirq_ff;
    assign alarm_irq_o = airq_ff;
    assign cal_out_o = cal_ff;

    rtcbk_store #(
        .DEPTH(rtcbk_pkg::BKP_COUNT),
        .WIDTH(rtcbk_pkg::BKP_WIDTH),
        .AW(rtcbk_pkg::BKP_AW)
    ) u_store (
        .clk_i(clk_i),
        .wr_en_i(bkp_wr_i),
        .addr_i(bkp_addr_i),
        .wdata_i(bkp_wdata_i),
        .rdata_o(bkp_rdata_o)
    ); // [R01] [R02]

    // assertions
    a_tick_counts: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        tick && !cnt_load_i |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("counter did not advance on tick");
    a_idle_holds: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
        !tick && !cnt_load_i |=> $stable(cnt_ff))
        else $error("counter moved without tick");
    a_tick_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        tick |=> sec_ff && sirq_ff)
        else $error("periodic flag missing after tick");
    // compare taken as it stood at the hit, a same-cycle compare load moves it
    a_alarm_set: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        alarm_hit |=> alm_ff && airq_ff && cnt_ff == $past(alarm_ff))
        else $error("alarm not raised at compare");
    a_alarm_cause: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        !alm_ff ##1 alm_ff |-> cnt_ff == $past(alarm_ff))
        else $error("alarm raised off compare");
    a_pre_reload: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        src_tick && pre_zero && !pre_load_i |=> pre_ff == reload_ff)
        else $error("prescaler did not reload");
    a_hse_div: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
        hse_div_ff |-> $past(hdiv_ff) == rtcbk_pkg::HSE_DIV_W'(rtcbk_pkg::HSE_DIV - 1))
        else $error("hse divide wrong");
    a_src_none: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
        src_sel_i == rtcbk_pkg::RTCBK_SRC_NONE |-> !tick)
        else $error("tick with no source");
    a_cal_off: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
        !cal_en_i |=> !cal_ff)
        else $error("calibration output while disabled");
    a_reset_reload: assert property (@(posedge clk_i) // [R07]
        srst_i |=> reload_ff == rtcbk_pkg::PRE_RELOAD_RST[PRE_W-1:0])
        else $error("reload reset value wrong");
    a_cnt_load: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        cnt_load_i |=> cnt_ff == $past(cnt_value_i))
        else $error("counter load not taken");
    a_alarm_load: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        alarm_load_i |=> alarm_ff == $past(alarm_value_i))
        else $error("compare load not taken");
    a_pre_load: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        pre_load_i |=> pre_ff == $past(pre_reload_i) && reload_ff == $past(pre_reload_i))
        else $error("prescaler load not taken");
    a_pre_count: assert property (@(posedge clk_i) disable iff (srst_i) // [R07]
        src_tick && !pre_zero && !pre_load_i |=> pre_ff == $past(pre_ff) - 1'b1)
        else $error("prescaler did not count down");
    a_pre_hold: assert property (@(posedge clk_i) disable iff (srst_i) // [R07]
        !src_tick && !pre_load_i |=> $stable(pre_ff))
        else $error("prescaler moved without source tick");
    a_reload_hold: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        !pre_load_i |=> $stable(reload_ff))
        else $error("reload value moved without load");
    // flags are sticky until cleared, and set wins over clear
    a_sec_sticky: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
        sec_ff && !sec_clr_i |=> sec_ff)
        else $error("periodic flag dropped without clear");
    a_sec_clear: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
        sec_clr_i && !tick |=> !sec_ff)
        else $error("periodic flag not cleared");
    a_sec_cause: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
        !sec_ff ##1 sec_ff |-> $past(tick))
        else $error("periodic flag set without tick");
    a_alarm_sticky: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        alm_ff && !alarm_clr_i |=> alm_ff)
        else $error("alarm flag dropped without clear");
    a_alarm_clear: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        alarm_clr_i && !alarm_hit |=> !alm_ff)
        else $error("alarm flag not cleared");
    a_sec_irq_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
        sirq_ff |-> sec_ff)
        else $error("periodic interrupt without flag");
    a_alarm_irq_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
        airq_ff |-> alm_ff)
        else $error("alarm interrupt without flag");
    // a deselected source must never reach the prescaler
    a_lse_gate: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
        src_sel_i == rtcbk_pkg::RTCBK_SRC_LSE && !lse_tick_i |-> !tick)
        else $error("tick without crystal tick");
    a_lsi_gate: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
        src_sel_i == rtcbk_pkg::RTCBK_SRC_LSI && !lsi_tick_i |-> !tick)
        else $error("tick without rc tick");
    a_hse_gate: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
        src_sel_i == rtcbk_pkg::RTCBK_SRC_HSE && !hse_div_ff |-> !tick)
        else $error("tick without divided high-speed tick");
    a_cal_on_tick: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
        $changed(cal_ff) |-> $past(lse_tick_i) || !$past(cal_en_i) || $past(srst_i))
        else $error("calibration output moved off a crystal tick");
    c_tick: cover property (@(posedge clk_i) disable iff (srst_i) tick);
    c_alarm: cover property (@(posedge clk_i) disable iff (srst_i) alarm_hit);
    c_cal: cover property (@(posedge clk_i) disable iff (srst_i) cal_en_i ##1 cal_ff);
    c_hse: cover property (@(posedge clk_i) disable iff (srst_i) hse_div_ff);
    c_wrap: cover property (@(posedge clk_i) disable iff (srst_i) tick && cnt_ff == '1);
endmodule
`default_nettype wire

// file: hdl/rtcbk_pkg.sv
// Purpose: constants for the real-time counter with backup store
// Assumes: one 20 MHz clock, no software bus
// Notes: clock sources arrive as enable ticks sampled on clk_i
`default_nettype none
package rtcbk_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int BKP_COUNT = 42;
    localparam int BKP_WIDTH = 16;
    localparam int BKP_AW = 6;
    localparam int PRE_WIDTH = 20;
    localparam int CNT_WIDTH = 32;
    localparam logic [19:0] PRE_RELOAD_RST = 20'h07fff;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] ALARM_RST = 32'hffff_ffff;
    localparam int HSE_DIV = 128;
    localparam int HSE_DIV_W = 7;
    localparam int CAL_DIV = 64;
    localparam int CAL_DIV_W = 6;
    typedef enum logic [1:0] {
        RTCBK_SRC_NONE,
        RTCBK_SRC_LSE,
        RTCBK_SRC_LSI,
        RTCBK_SRC_HSE
    } rtcbk_src_t;
endpackage
`default_nettype wire

// file: hdl/rtcbk_store.sv
// Purpose: battery-backed register store
// Assumes: write port synchronous to clk_i
// Notes: deliberately no reset input, contents survive every reset
`default_nettype none
module rtcbk_store #(
    parameter int DEPTH = rtcbk_pkg::BKP_COUNT,
    parameter int WIDTH = rtcbk_pkg::BKP_WIDTH,
    parameter int AW = rtcbk_pkg::BKP_AW
) (
    // clock
    input wire logic clk_i,
    // access
    input wire logic wr_en_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    wire addr_ok = (32'(addr_i) < DEPTH);

    // no reset term here so system, power and standby resets leave data [R02]
    always_ff @(posedge clk_i) begin
        if (wr_en_i && addr_ok) begin
            mem_ff[addr_i] <= wdata_i; // [R01]
        end
        rdata_o <= addr_ok ? mem_ff[addr_i] : '0;
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: self-checking bench for the real-time counter block
// Assumes: source ticks driven as one-cycle enables, 1 ns after the edge
// Notes: default divide is run in full, about 33k cycles
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ps;
logic clk_i = 0, srst_i = 1, lse_tick_i = 0, lsi_tick_i = 0, hse_tick_i = 0, cal_en_i = 0;
logic pre_load_i = 0, cnt_load_i = 0, alarm_load_i = 0, sec_clr_i = 0, alarm_clr_i = 0;
logic bkp_wr_i = 0, sec_flag_o, alarm_flag_o, sec_irq_o, alarm_irq_o, cal_out_o;
rtcbk_pkg::rtcbk_src_t src_sel_i = rtcbk_pkg::RTCBK_SRC_LSE;
logic [19:0] pre_reload_i = 20'h0;
logic [31:0] cnt_value_i = 32'h0, alarm_value_i = 32'h0, count_o;
logic [5:0] bkp_addr_i = 6'h0;
logic [15:0] bkp_wdata_i = 16'h0, bkp_rdata_o;
int errors = 0, n_tests = 0;
always #25 clk_i = ~clk_i;
rtcbk_top rtcbk_top_i (.clk_i, .srst_i, .lse_tick_i, .lsi_tick_i, .hse_tick_i, .src_sel_i,
    .cal_en_i, .pre_load_i, .pre_reload_i, .cnt_load_i, .cnt_value_i, .alarm_load_i,
    .alarm_value_i, .sec_clr_i, .alarm_clr_i, .bkp_wr_i, .bkp_addr_i, .bkp_wdata_i,
    .bkp_rdata_o, .count_o, .sec_flag_o, .alarm_flag_o, .sec_irq_o, .alarm_irq_o, .cal_out_o);
task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
        errors++;
        $display("BAD %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
endtask
// tick held on one source for n edges: 1 crystal, 2 rc, 3 high-speed
// left standing so back-to-back calls never drop it; idle lowers it
task automatic tick(int n, int which);
    lse_tick_i = (which == 1);
    lsi_tick_i = (which == 2);
    hse_tick_i = (which == 3);
    step(n);
endtask
task automatic idle(int n);
    {lse_tick_i, lsi_tick_i, hse_tick_i} = 3'h0;
    step(n);
endtask
task automatic t_cal_default;
    chk("count rst", count_o, 32'h0); // reset
    cal_en_i = 1;
    tick(31, 1);
    chk("cal early", cal_out_o, 1'b0); // cal
    tick(1, 1);
    idle(1);
    chk("cal toggle", cal_out_o, 1'b1); // cal
    cal_en_i = 0;
    step(2);
    chk("cal off", cal_out_o, 1'b0); // cal
    tick(32735, 1);
    chk("count early", count_o, 32'h0); // one second
    tick(1, 1);
    chk("count sec", count_o, 32'h1); // one second
    chk("sec irq", sec_irq_o, 1'b1); // periodic
    chk("sec flag", sec_flag_o, 1'b1); // periodic
    idle(1);
    chk("sec irq end", sec_irq_o, 1'b0); // pulse
    sec_clr_i = 1;
    step(1);
    sec_clr_i = 0;
    chk("sec clr", sec_flag_o, 1'b0); // clear
endtask
task automatic t_alarm;
    {pre_load_i, cnt_load_i, alarm_load_i} = 3'h7;
    pre_reload_i = 20'h3;
    cnt_value_i = 32'hffff_fffd;
    alarm_value_i = 32'hffff_fffe;
    step(1);
    {pre_load_i, cnt_load_i, alarm_load_i} = 3'h0;
    chk("cnt load", count_o, 32'hffff_fffd); // load
    tick(3, 1);
    chk("reload div", count_o, 32'hffff_fffd); // divide
    chk("no alarm", alarm_flag_o, 1'b0); // alarm
    tick(1, 1);
    chk("alarm cnt", count_o, 32'hffff_fffe); // divide
    chk("alarm irq", alarm_irq_o, 1'b1); // alarm
    idle(1);
    chk("alarm irq end", alarm_irq_o, 1'b0); // pulse
    chk("alarm flag", alarm_flag_o, 1'b1); // sticky
    alarm_clr_i = 1;
    step(1);
    alarm_clr_i = 0;
    chk("alarm clr", alarm_flag_o, 1'b0); // clear
endtask
task automatic t_sources;
    pre_load_i = 1;
    pre_reload_i = 20'h0;
    step(1);
    pre_load_i = 0;
    src_sel_i = rtcbk_pkg::RTCBK_SRC_NONE;
    tick(3, 1);
    chk("src none", count_o, 32'hffff_fffe); // stopped
    src_sel_i = rtcbk_pkg::RTCBK_SRC_LSI;
    tick(1, 1);
    tick(2, 2);
    chk("src rc wrap", count_o, 32'h0); // rc only
    src_sel_i = rtcbk_pkg::RTCBK_SRC_HSE;
    tick(127, 3);
    idle(1);
    chk("hse 127", count_o, 32'h0); // div 128
    tick(1, 3);
    idle(1);
    chk("hse 128", count_o, 32'h1); // div 128
endtask
task automatic t_backup;
    bkp_wr_i = 1;
    for (int a = 0; a < 43; a++) begin
        bkp_addr_i = a[5:0];
        bkp_wdata_i = 16'ha500 + 16'(a);
        step(1);
    end
    bkp_wr_i = 0;
    srst_i = 1; // survives reset
    step(2);
    srst_i = 0;
    chk("count rst2", count_o, 32'h0); // reset
    chk("flag rst2", sec_flag_o, 1'b0); // reset
    for (int a = 0; a < 43; a++) begin
        bkp_addr_i = a[5:0];
        step(1);
        chk("bkp read", bkp_rdata_o, (a < 42) ? 32'ha500 + a : 32'h0); // store
    end
endtask
task automatic conclude;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
initial begin
    step(8);
    srst_i = 0;
    t_cal_default();
    t_alarm();
    t_sources();
    t_backup();
    conclude();
end
initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    conclude();
end
endmodule
`default_nettype wire
